/* File: inc/exc_pkg.sv */
// Purpose: shared constants for the cpu exception sequencer
// Assumes: 32-bit addresses, 16-bit instructions, 40 MHz core clock
// Notes:   vector numbers follow the exception vector table layout
// Summary of operation
// RQ1: odd instruction fetch address flags an address error
// RQ2: instruction fetch from peripheral module space flags an address error
// RQ3: cpu or dma word access at odd address flags an address error
// RQ4: cpu or dma long access not on four-byte boundary flags an error
// RQ5: long access to 8-bit peripheral area errors; 16-bit areas are fine
// RQ6: address error handling waits for bus cycle and executing instructions
// RQ7: address error pushes status, pushes pc, jumps via vector, no slot
// RQ8: address error saves start of instruction after last one executed
// RQ9: sources: nmi, break, eight external, 4 dma, 15 timer, 8 serial, wdt, 2 bus
// RQ10: levels 0 to 16; nmi fixed 16 always taken, break fixed 15
// RQ11: external and peripheral sources take programmable levels 0 to 15
// RQ12: with several pending, the highest ranked request is handled
// RQ13: maskable request accepted only when level exceeds the mask field
// RQ14: interrupt pushes status and pc, writes level to mask, jumps via vector
// RQ15: nmi writes fifteen into the mask field instead of sixteen
// RQ16: trap pushes status and next pc, uses its own vector, no slot
// RQ17: undefined or pc-writing code in a delay slot starts illegal slot handling
// RQ18: illegal slot saves the delayed branch target and uses its vector
// RQ19: undefined code outside a slot saves its own address, general vector
// RQ20: handler address is vector base plus four times vector number
// RQ21: trap can select user vectors 32 through 63
// RQ22: each push decrements stack pointer by four before writing
// RQ23: equal levels are resolved by fixed source order
package exc_pkg;
  // access sizes on the data side
  localparam logic [1:0]  SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  SIZE_WORD      = 2'h1;
  localparam logic [1:0]  SIZE_LONG      = 2'h2;
  // peripheral module space: address bits 27..24 select it
  localparam logic [3:0]  PERIPH_TAG     = 4'h5;
  localparam int          PERIPH_TAG_LSB = 24;
  // within peripheral space this address bit marks an 8-bit area when low
  localparam int          PERIPH_W16_BIT = 8;
  // vector numbers
  localparam logic [7:0]  VEC_GEN_ILL    = 8'h04;
  localparam logic [7:0]  VEC_SLOT_ILL   = 8'h06;
  localparam logic [7:0]  VEC_CPU_AE     = 8'h09;
  localparam logic [7:0]  VEC_DMA_AE     = 8'h0a;
  localparam logic [7:0]  VEC_NMI        = 8'h0b;
  localparam logic [7:0]  VEC_BREAK      = 8'h0c;
  localparam logic [7:0]  VEC_EXT_BASE   = 8'h40;
  localparam logic [7:0]  VEC_ONCHIP     = 8'h48;
  // source counts
  localparam int          N_EXT          = 8;
  localparam int          N_ONCHIP       = 30;  // 4 dma, 15 timer, 8 serial, 1 wdt, 2 bus
  localparam int          N_SRC          = 2 + N_EXT + N_ONCHIP;
  localparam int          SRC_NMI        = 0;
  localparam int          SRC_BREAK      = 1;
  localparam int          SRC_EXT        = 2;
  localparam int          SRC_ONCHIP     = SRC_EXT + N_EXT;
  // priority levels
  localparam logic [4:0]  LVL_NMI        = 5'h10;
  localparam logic [4:0]  LVL_BREAK      = 5'h0f;
  localparam logic [3:0]  MASK_NMI       = 4'hf;
  // mask field position inside the status word
  localparam int          MASK_LSB       = 4;
  // stack and instruction steps in bytes
  localparam logic [31:0] PUSH_BYTES     = 32'h0000_0004;
  localparam logic [31:0] INSTR_BYTES    = 32'h0000_0002;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PUSH_SR = 2'b01,
    ST_PUSH_PC = 2'b10,
    ST_READ_VEC = 2'b11
  } seq_state_t;
endpackage : exc_pkg

/* File: hw/cpu_exception_sequencer.sv */
// Purpose: address error check, interrupt ranking and exception entry sequence
// Assumes: one bus request at a time, held until mem_ack_in
// Notes:   vector fetch ack carries the handler address on mem_rdata_in
`timescale 1ns/1ps
module cpu_exception_sequencer (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  // instruction fetch check
  input  wire logic                       fetch_valid_in,
  input  wire logic [31:0]                fetch_addr_in,
  // data access check (cpu or dma)
  input  wire logic                       data_valid_in,
  input  wire logic                       data_dma_in,
  input  wire logic [1:0]                 data_size_in,
  input  wire logic [31:0]                data_addr_in,
  // pipeline state
  input  wire logic                       pipe_drained_in,
  input  wire logic [31:0]                next_pc_in,
  input  wire logic                       decode_valid_in,
  input  wire logic [31:0]                decode_pc_in,
  input  wire logic                       decode_undef_in,
  input  wire logic                       decode_pc_write_in,
  input  wire logic                       decode_trap_in,
  input  wire logic [7:0]                 trap_vector_in,
  input  wire logic                       in_delay_slot_in,
  input  wire logic [31:0]                branch_target_in,
  input  wire logic                       int_block_in,
  // interrupt sources and levels
  input  wire logic                       nmi_req_in,
  input  wire logic                       break_req_in,
  input  wire logic [exc_pkg::N_EXT-1:0]  external_request_lines_in,
  input  wire logic [exc_pkg::N_ONCHIP-1:0] onchip_req_in,
  input  wire logic [4*exc_pkg::N_EXT-1:0] ext_level_in,
  input  wire logic [4*exc_pkg::N_ONCHIP-1:0] onchip_level_in,
  // core registers
  input  wire logic [31:0]                status_word_in,
  input  wire logic [31:0]                stack_pointer_in,
  input  wire logic [31:0]                vector_base_in,
  // memory port
  input  wire logic                       mem_ack_in,
  input  wire logic [31:0]                mem_rdata_in,
  output logic                            mem_req_out,
  output logic                            mem_we_out,
  output logic [31:0]                     mem_addr_out,
  output logic [31:0]                     mem_wdata_out,
  // results to the core
  output logic                            busy_out,
  output logic                            addr_error_out,
  output logic                            pc_load_out,
  output logic [31:0]                     program_counter_out,
  output logic                            sp_load_out,
  output logic [31:0]                     stack_pointer_out,
  output logic                            mask_load_out,
  output logic [3:0]                      interrupt_mask_field_out,
  output logic                            int_ack_out,
  output logic [5:0]                      int_ack_src_out
);

  exc_pkg::seq_state_t state_ff;
  logic        ae_cpu_ff;
  logic        ae_dma_ff;
  logic [7:0]  vec_ff;
  logic [31:0] saved_pc_ff;
  logic        is_int_ff;
  logic        is_ae_ff;
  logic [4:0]  lvl_ff;
  logic [4:0]  src_lvl [exc_pkg::N_SRC];
  logic [7:0]  src_vec [exc_pkg::N_SRC];
  logic [4:0]  win_lvl;
  logic [5:0]  win_src;
  logic        fetch_periph;
  logic        data_periph;
  logic        fetch_err;
  logic        data_err;
  logic        slot_ill;
  logic        gen_ill;
  logic        trap_go;
  logic        ae_go;
  logic        int_go;
  logic        start;
  logic [3:0]  cur_mask;

  // address error detection
  assign fetch_periph = fetch_addr_in[exc_pkg::PERIPH_TAG_LSB +: 4] == exc_pkg::PERIPH_TAG;
  assign data_periph  = data_addr_in[exc_pkg::PERIPH_TAG_LSB +: 4] == exc_pkg::PERIPH_TAG;
  assign fetch_err = fetch_valid_in & (fetch_addr_in[0]   // RQ1
                                       | fetch_periph);   // RQ2
  assign data_err  = data_valid_in &
                     (((data_size_in == exc_pkg::SIZE_WORD) & data_addr_in[0])              // RQ3
                      | ((data_size_in == exc_pkg::SIZE_LONG) & (data_addr_in[1:0] != 2'h0)) // RQ4
                      | ((data_size_in == exc_pkg::SIZE_LONG) & data_periph
                         & ~data_addr_in[exc_pkg::PERIPH_W16_BIT]));                       // RQ5

  // source table: rank, vector per source
  genvar gi;
  generate
    for (gi = 0; gi < exc_pkg::N_SRC; gi++) begin : g_src
      if (gi == exc_pkg::SRC_NMI) begin : g_nmi
        assign src_lvl[gi] = nmi_req_in ? exc_pkg::LVL_NMI : 5'h00;        // RQ10
        assign src_vec[gi] = exc_pkg::VEC_NMI;
      end else if (gi == exc_pkg::SRC_BREAK) begin : g_brk
        assign src_lvl[gi] = break_req_in ? exc_pkg::LVL_BREAK : 5'h00;    // RQ10
        assign src_vec[gi] = exc_pkg::VEC_BREAK;
      end else if (gi < exc_pkg::SRC_ONCHIP) begin : g_ext
        assign src_lvl[gi] = external_request_lines_in[gi-exc_pkg::SRC_EXT]
                             ? {1'b0, ext_level_in[4*(gi-exc_pkg::SRC_EXT) +: 4]} : 5'h00; // RQ11
        assign src_vec[gi] = exc_pkg::VEC_EXT_BASE + 8'(gi - exc_pkg::SRC_EXT);
      end else begin : g_onc
        assign src_lvl[gi] = onchip_req_in[gi-exc_pkg::SRC_ONCHIP]
                             ? {1'b0, onchip_level_in[4*(gi-exc_pkg::SRC_ONCHIP) +: 4]} : 5'h00; // RQ9 RQ11
        assign src_vec[gi] = exc_pkg::VEC_ONCHIP + 8'(gi - exc_pkg::SRC_ONCHIP);
      end
    end
  endgenerate

  // pick highest level; strict compare keeps the lowest index on ties
  always_comb begin
    win_lvl = 5'h00;
    win_src = 6'h00;
    for (int i = 0; i < exc_pkg::N_SRC; i++) begin
      if (src_lvl[i] > win_lvl) begin   // RQ12 RQ23
        win_lvl = src_lvl[i];
        win_src = 6'(i);
      end
    end
  end

  // start conditions; decode-time faults win over deferred ones
  assign cur_mask = status_word_in[exc_pkg::MASK_LSB +: 4];
  assign slot_ill = decode_valid_in & in_delay_slot_in
                    & (decode_undef_in | decode_pc_write_in | decode_trap_in);   // RQ17
  assign gen_ill  = decode_valid_in & ~in_delay_slot_in & decode_undef_in;       // RQ19
  assign trap_go  = decode_valid_in & ~in_delay_slot_in & decode_trap_in & ~decode_undef_in;
  // address errors wait for the drain and never split a branch from its slot
  assign ae_go    = (ae_cpu_ff | ae_dma_ff) & pipe_drained_in & ~in_delay_slot_in; // RQ6
  assign int_go   = (win_src == 6'(exc_pkg::SRC_NMI) ? nmi_req_in
                     : (win_lvl > {1'b0, cur_mask}))                               // RQ13
                    & ~in_delay_slot_in & ~int_block_in & pipe_drained_in;
  assign start    = (state_ff == exc_pkg::ST_IDLE)
                    & (slot_ill | gen_ill | trap_go | ae_go | int_go);

  // pending address error flags; a new error beats the clear at start
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ae_cpu_ff      <= 1'b0;
      ae_dma_ff      <= 1'b0;
      addr_error_out <= 1'b0;
    end else begin
      // errors raised while an address error entry is stacking are ignored to avoid a loop
      if (start & ~(slot_ill | gen_ill | trap_go) & ae_go) begin
        if (ae_cpu_ff) ae_cpu_ff <= 1'b0;
        else ae_dma_ff <= 1'b0;
      end
      if (state_ff == exc_pkg::ST_IDLE || !is_ae_ff) begin
        if (fetch_err | (data_err & ~data_dma_in)) ae_cpu_ff <= 1'b1;   // RQ1 RQ3
        if (data_err & data_dma_in) ae_dma_ff <= 1'b1;                  // RQ3 RQ4
      end
      addr_error_out <= fetch_err | data_err;
    end
  end

  // sequence state machine
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= exc_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        exc_pkg::ST_IDLE:     if (start) state_ff <= exc_pkg::ST_PUSH_SR;
        exc_pkg::ST_PUSH_SR:  if (mem_ack_in) state_ff <= exc_pkg::ST_PUSH_PC;   // RQ7 RQ14
        exc_pkg::ST_PUSH_PC:  if (mem_ack_in) state_ff <= exc_pkg::ST_READ_VEC;
        exc_pkg::ST_READ_VEC: if (mem_ack_in) state_ff <= exc_pkg::ST_IDLE;
        default:              state_ff <= exc_pkg::ST_IDLE;
      endcase
    end
  end

  // capture kind, vector and saved pc at start
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      vec_ff      <= 8'h00;
      saved_pc_ff <= 32'h0000_0000;
      is_int_ff   <= 1'b0;
      is_ae_ff    <= 1'b0;
      lvl_ff      <= 5'h00;
    end else if (start) begin
      is_int_ff <= 1'b0;
      is_ae_ff  <= 1'b0;
      lvl_ff    <= win_lvl;
      if (slot_ill) begin
        vec_ff      <= exc_pkg::VEC_SLOT_ILL;
        saved_pc_ff <= branch_target_in;                         // RQ18
      end else if (gen_ill) begin
        vec_ff      <= exc_pkg::VEC_GEN_ILL;
        saved_pc_ff <= decode_pc_in;                             // RQ19
      end else if (trap_go) begin
        vec_ff      <= trap_vector_in;                           // RQ16 RQ21
        saved_pc_ff <= decode_pc_in + exc_pkg::INSTR_BYTES;      // RQ16
      end else if (ae_go) begin
        vec_ff      <= ae_cpu_ff ? exc_pkg::VEC_CPU_AE : exc_pkg::VEC_DMA_AE;
        saved_pc_ff <= next_pc_in;                               // RQ8
        is_ae_ff    <= 1'b1;
      end else begin
        vec_ff      <= src_vec[win_src];
        saved_pc_ff <= next_pc_in;
        is_int_ff   <= 1'b1;
      end
    end
  end

  // memory port: pushes and vector read
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mem_req_out       <= 1'b0;
      mem_we_out        <= 1'b0;
      mem_addr_out      <= 32'h0000_0000;
      mem_wdata_out     <= 32'h0000_0000;
      stack_pointer_out <= 32'h0000_0000;
    end else begin
      if (start) begin
        mem_req_out       <= 1'b1;
        mem_we_out        <= 1'b1;
        mem_addr_out      <= stack_pointer_in - exc_pkg::PUSH_BYTES;   // RQ22
        stack_pointer_out <= stack_pointer_in - exc_pkg::PUSH_BYTES;
        mem_wdata_out     <= status_word_in;                           // RQ7 RQ14 RQ16
      end else if (mem_ack_in && state_ff == exc_pkg::ST_PUSH_SR) begin
        mem_addr_out      <= stack_pointer_out - exc_pkg::PUSH_BYTES;  // RQ22
        stack_pointer_out <= stack_pointer_out - exc_pkg::PUSH_BYTES;
        mem_wdata_out     <= saved_pc_ff;
      end else if (mem_ack_in && state_ff == exc_pkg::ST_PUSH_PC) begin
        mem_we_out   <= 1'b0;
        mem_addr_out <= vector_base_in + {22'h000000, vec_ff, 2'h0};   // RQ20
      end else if (mem_ack_in && state_ff == exc_pkg::ST_READ_VEC) begin
        mem_req_out <= 1'b0;
      end
    end
  end

  // results: direct jump, no delay slot; mask update on interrupts
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      busy_out                 <= 1'b0;
      pc_load_out              <= 1'b0;
      program_counter_out      <= 32'h0000_0000;
      sp_load_out              <= 1'b0;
      mask_load_out            <= 1'b0;
      interrupt_mask_field_out <= 4'h0;
      int_ack_out              <= 1'b0;
      int_ack_src_out          <= 6'h00;
    end else begin
      pc_load_out   <= 1'b0;
      sp_load_out   <= 1'b0;
      mask_load_out <= 1'b0;
      int_ack_out   <= 1'b0;
      if (start) busy_out <= 1'b1;
      if (start & ~(slot_ill | gen_ill | trap_go | ae_go)) begin
        int_ack_out     <= 1'b1;
        int_ack_src_out <= win_src;
      end
      if (mem_ack_in && state_ff == exc_pkg::ST_READ_VEC) begin
        busy_out            <= 1'b0;
        pc_load_out         <= 1'b1;                           // RQ7 RQ16 RQ18
        program_counter_out <= mem_rdata_in;
        sp_load_out         <= 1'b1;
        mask_load_out       <= is_int_ff;                      // RQ14
        interrupt_mask_field_out <= (lvl_ff == exc_pkg::LVL_NMI) ? exc_pkg::MASK_NMI
                                    : lvl_ff[3:0];             // RQ15
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_odd_fetch_flag:  assert property (fetch_valid_in && fetch_addr_in[0] |=> addr_error_out) // RQ1
    else $error("odd fetch not flagged");
  a_periph_fetch:    assert property (fetch_valid_in && fetch_periph |=> addr_error_out) // RQ2
    else $error("peripheral fetch not flagged");
  a_word_odd:        assert property (data_valid_in && data_size_in == exc_pkg::SIZE_WORD
                                      && data_addr_in[0] |=> addr_error_out) // RQ3
    else $error("odd word access not flagged");
  a_long_misalign:   assert property (data_valid_in && data_size_in == exc_pkg::SIZE_LONG
                                      && data_addr_in[1:0] != 2'h0 |=> addr_error_out) // RQ4
    else $error("misaligned long access not flagged");
  a_ae_waits_drain:  assert property ($rose(busy_out) && is_ae_ff |-> $past(pipe_drained_in)) // RQ6
    else $error("address error started before drain");
  a_push_order:      assert property (state_ff == exc_pkg::ST_PUSH_SR && mem_ack_in
                                      |=> state_ff == exc_pkg::ST_PUSH_PC && mem_we_out
                                      && mem_wdata_out == saved_pc_ff) // RQ7
    else $error("pc push did not follow status push");
  a_sp_decrement:    assert property (state_ff == exc_pkg::ST_PUSH_SR && mem_ack_in
                                      |=> stack_pointer_out == $past(stack_pointer_out) - exc_pkg::PUSH_BYTES) // RQ22
    else $error("stack pointer not decremented by four");
  a_vec_address:     assert property (state_ff == exc_pkg::ST_PUSH_PC && mem_ack_in
                                      |=> mem_addr_out == vector_base_in + {22'h000000, vec_ff, 2'h0}) // RQ20
    else $error("wrong vector address");
  a_mask_gate:       assert property (int_ack_out && int_ack_src_out != 6'(exc_pkg::SRC_NMI)
                                      |-> lvl_ff > {1'b0, $past(cur_mask)}) // RQ13
    else $error("interrupt taken at or below mask");
  a_nmi_mask:        assert property (mask_load_out && lvl_ff == exc_pkg::LVL_NMI
                                      |-> interrupt_mask_field_out == exc_pkg::MASK_NMI) // RQ15
    else $error("nmi did not set mask to fifteen");
  a_slot_saves_tgt:  assert property (start && slot_ill |=> saved_pc_ff == $past(branch_target_in)
                                      && vec_ff == exc_pkg::VEC_SLOT_ILL) // RQ18
    else $error("illegal slot saved wrong pc");
  a_trap_next_pc:    assert property (start && trap_go && !slot_ill |=> saved_pc_ff == $past(decode_pc_in)
                                      + exc_pkg::INSTR_BYTES) // RQ16
    else $error("trap saved wrong pc");

  c_int_entry:  cover property (int_ack_out ##[1:40] pc_load_out);
  c_ae_entry:   cover property (is_ae_ff && pc_load_out);
  c_slot_entry: cover property (start && slot_ill);

endmodule : cpu_exception_sequencer

/* File: testbench/mem_partner.sv */
// Purpose: memory side model for the stack pushes and the vector read
// Assumes: one request held until it is acknowledged
// Notes:   read data toggles while idle so stale data never looks valid
`timescale 1ns/1ps
module mem_partner (
  // clock, reset and wait states
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [1:0]  delay_in,
  // request side
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  // answer side
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [1:0] wait_ff;
  // count wait states, then acknowledge for one cycle
  always_ff @(posedge clk_in) begin
    if (reset_in || !req_in || ack_out) begin
      wait_ff <= 2'h0;
      ack_out <= 1'h0;
    end else if (wait_ff == delay_in) begin
      ack_out <= 1'h1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
  // handler word is the vector address moved up; idle data keeps changing
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0;
    end else if (req_in && !we_in && !ack_out && wait_ff == delay_in) begin
      rdata_out <= addr_in + 32'h0001_0000;
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule : mem_partner

/* File: testbench/cpu_exception_sequencer_bench.sv */
// Purpose: self-checking bench for the exception sequencer
// Assumes: memory model answers with 0 to 2 wait states
// Notes:   expected stack and vector values are worked out here
`timescale 1ns/1ps
module cpu_exception_sequencer_bench;
  logic core_clk_in = 1'h0, reset_in = 1'h1, mem_ack_in, mem_req_out, mem_we_out, busy_out, addr_error_out;
  logic fetch_valid_in, data_valid_in, data_dma_in, pipe_drained_in, decode_valid_in, decode_undef_in;
  logic decode_pc_write_in, decode_trap_in, in_delay_slot_in, int_block_in, nmi_req_in, break_req_in;
  logic pc_load_out, sp_load_out, mask_load_out, int_ack_out;
  logic [1:0] data_size_in, delay;
  logic [3:0] interrupt_mask_field_out;
  logic [5:0] int_ack_src_out;
  logic [7:0] trap_vector_in;
  logic [exc_pkg::N_EXT-1:0] external_request_lines_in;
  logic [exc_pkg::N_ONCHIP-1:0] onchip_req_in;
  logic [4*exc_pkg::N_EXT-1:0] ext_level_in;
  logic [4*exc_pkg::N_ONCHIP-1:0] onchip_level_in;
  logic [31:0] fetch_addr_in, data_addr_in, next_pc_in, decode_pc_in, branch_target_in, status_word_in;
  logic [31:0] stack_pointer_in, vector_base_in, mem_rdata_in, mem_addr_out, mem_wdata_out;
  logic [31:0] program_counter_out, stack_pointer_out, ra, wa [2], wd [2];
  int fail_count = 0, cmp_count = 0, cycles = 0, k;

  cpu_exception_sequencer uut (.core_clk_in, .reset_in, .fetch_valid_in, .fetch_addr_in, .data_valid_in,
    .data_dma_in, .data_size_in, .data_addr_in, .pipe_drained_in, .next_pc_in, .decode_valid_in, .decode_pc_in,
    .decode_undef_in, .decode_pc_write_in, .decode_trap_in, .trap_vector_in, .in_delay_slot_in,
    .branch_target_in, .int_block_in, .nmi_req_in, .break_req_in, .external_request_lines_in, .onchip_req_in,
    .ext_level_in, .onchip_level_in, .status_word_in, .stack_pointer_in, .vector_base_in, .mem_ack_in,
    .mem_rdata_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .busy_out, .addr_error_out,
    .pc_load_out, .program_counter_out, .sp_load_out, .stack_pointer_out, .mask_load_out,
    .interrupt_mask_field_out, .int_ack_out, .int_ack_src_out);
  mem_partner partner (.clk_in(core_clk_in), .reset_in(reset_in), .delay_in(delay), .req_in(mem_req_out),
    .we_in(mem_we_out), .addr_in(mem_addr_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  always #12.5 core_clk_in = ~core_clk_in;
  // snoop completed cycles: writes shift so index 0 is the first push
  always @(posedge core_clk_in) begin
    if (mem_req_out && mem_ack_in && mem_we_out) begin
      wa[0] <= wa[1]; wa[1] <= mem_addr_out; wd[0] <= wd[1]; wd[1] <= mem_wdata_out;
    end else if (mem_req_out && mem_ack_in) ra <= mem_addr_out;
  end
  // hang guard, generous against the few hundred cycles needed
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin fail_count++; wrap_up(); end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin fail_count++; $display("[FAIL] %s expected %h seen %h", what, exp, got); end
  endtask : chk
  // request inputs drop together once the sequencer has taken them
  task automatic clr;
    fetch_valid_in <= '0; data_valid_in <= '0; decode_valid_in <= '0; decode_undef_in <= '0;
    decode_pc_write_in <= '0; decode_trap_in <= '0; in_delay_slot_in <= '0; nmi_req_in <= '0;
    break_req_in <= '0; external_request_lines_in <= '0; onchip_req_in <= '0;
  endtask : clr
  function automatic logic ae_exp(input logic f, input logic [1:0] sz, input logic [31:0] a);
    logic per;
    per = a[27:24] == exc_pkg::PERIPH_TAG;
    if (f) return a[0] | per;
    return (sz == exc_pkg::SIZE_WORD && a[0]) || (sz == exc_pkg::SIZE_LONG && (a[1:0] != 2'h0 || (per && !a[8])));
  endfunction : ae_exp
  task automatic ae(input logic f, input logic [1:0] sz, input logic [31:0] a);
    @(posedge core_clk_in);
    fetch_valid_in <= f; data_valid_in <= !f; fetch_addr_in <= a; data_addr_in <= a;
    data_size_in <= sz; data_dma_in <= a[4];
    @(posedge core_clk_in);
    clr();
    #1 chk("addr_error", 32'(ae_exp(f, sz, a)), 32'(addr_error_out));
  endtask : ae
  // one full entry: stack pushes, vector read, results
  task automatic run(input logic [31:0] spc, input logic [7:0] vec, input logic isint, input logic [3:0] msk,
                     input logic [5:0] src);
    int n;
    n = 0;
    delay <= 2'($urandom % 3);
    do begin @(posedge core_clk_in); #1; n++; end while (busy_out !== 1'h1 && n < 20);
    chk("int_ack", 32'(isint), 32'(int_ack_out));
    if (isint) chk("ack_src", 32'(src), 32'(int_ack_src_out));
    clr();
    n = 0;
    do begin @(posedge core_clk_in); #1; n++; end while (pc_load_out !== 1'h1 && n < 40);
    chk("push1_addr", stack_pointer_in - 32'h4, wa[0]);
    chk("push1_data", status_word_in, wd[0]);
    chk("push2_addr", stack_pointer_in - 32'h8, wa[1]);
    chk("push2_data", spc, wd[1]);
    chk("vec_addr", vector_base_in + {22'h0, vec, 2'h0}, ra);
    chk("handler", ra + 32'h0001_0000, program_counter_out);
    chk("sp_final", stack_pointer_in - 32'h8, stack_pointer_out);
    chk("sp_load", 1, 32'(sp_load_out));
    chk("mask_load", 32'(isint), 32'(mask_load_out));
    if (isint) chk("mask", 32'(msk), 32'(interrupt_mask_field_out));
  endtask : run

  initial begin
    void'($urandom(78));
    clr();
    {data_dma_in, pipe_drained_in, int_block_in, data_size_in, delay, trap_vector_in} = '0;
    {fetch_addr_in, data_addr_in, decode_pc_in, ext_level_in, onchip_level_in} = '0;
    {next_pc_in, branch_target_in, status_word_in} = {32'h0000_2468, 32'h0000_3a00, 32'h0};
    {stack_pointer_in, vector_base_in} = {32'h0000_8000 + (($urandom % 256) << 2), 32'h0000_1000};
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'h0;
    // address checks: corner cases, then random ones
    ae(1, 0, 32'h0000_0100); ae(1, 0, 32'h0000_0101); ae(1, 0, 32'h0500_0000); ae(0, 1, 32'h0000_0011);
    ae(0, 1, 32'h0000_0012); ae(0, 2, 32'h0000_0002); ae(0, 2, 32'h0000_0004); ae(0, 0, 32'h0500_0001);
    ae(0, 2, 32'h0500_0100); ae(0, 2, 32'h0500_0004); ae(0, 1, 32'h0500_0003);
    for (k = 0; k < 30; k++) ae(1'($urandom), 2'($urandom % 3), $urandom);
    repeat (3) @(posedge core_clk_in);
    #1 chk("busy_undrained", 0, 32'(busy_out));
    $display("test address checks done");
    @(posedge core_clk_in);
    pipe_drained_in <= 1'h1;
    run(next_pc_in, exc_pkg::VEC_CPU_AE, 0, 0, 0);
    run(next_pc_in, exc_pkg::VEC_DMA_AE, 0, 0, 0);
    $display("test address error entry done");
    // masked request, then a tie at level 7 between line 3 and onchip 0
    @(posedge core_clk_in);
    status_word_in <= 32'h50; ext_level_in[15:8] <= 8'h75; onchip_level_in[3:0] <= 4'h7;
    external_request_lines_in <= 8'h04;
    repeat (6) @(posedge core_clk_in);
    #1 chk("busy_masked", 0, 32'(busy_out));
    @(posedge core_clk_in);
    external_request_lines_in <= 8'h0c; onchip_req_in <= 30'h1;
    run(next_pc_in, exc_pkg::VEC_EXT_BASE + 8'h3, 1, 4'h7, 6'h5);
    @(posedge core_clk_in);
    status_word_in <= 32'he0; ext_level_in[3:0] <= 4'hf; external_request_lines_in <= 8'h01; break_req_in <= 1;
    run(next_pc_in, exc_pkg::VEC_BREAK, 1, 4'hf, 6'h1);
    @(posedge core_clk_in);
    status_word_in <= 32'hf0; nmi_req_in <= 1; break_req_in <= 1;
    run(next_pc_in, exc_pkg::VEC_NMI, 1, exc_pkg::MASK_NMI, 6'h0);
    for (k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      onchip_level_in <= 120'h6 << (4 * k * 7); onchip_req_in <= 30'h1 << (k * 7);
      status_word_in <= 32'h50;
      run(next_pc_in, exc_pkg::VEC_ONCHIP + 8'(k * 7), 1, 4'h6, 6'(10 + k * 7));
    end
    $display("test interrupts done");
    status_word_in <= 32'h0;
    for (k = 0; k < 2; k++) begin
      @(posedge core_clk_in);
      decode_pc_in <= $urandom << 1; decode_valid_in <= 1; decode_trap_in <= 1; trap_vector_in <= 8'(32 + k * 31);
      #1 run(decode_pc_in + exc_pkg::INSTR_BYTES, trap_vector_in, 0, 0, 0);
    end
    for (k = 0; k < 3; k++) begin
      @(posedge core_clk_in);
      decode_valid_in <= 1; in_delay_slot_in <= 1; decode_undef_in <= k == 0;
      decode_pc_write_in <= k == 1; decode_trap_in <= k == 2;
      run(branch_target_in, exc_pkg::VEC_SLOT_ILL, 0, 0, 0);
    end
    @(posedge core_clk_in);
    decode_valid_in <= 1; decode_undef_in <= 1;
    run(decode_pc_in, exc_pkg::VEC_GEN_ILL, 0, 0, 0);
    $display("test instruction exceptions done");
    wrap_up();
  end
endmodule : cpu_exception_sequencer_bench
